// ===== rtl/card_slot_host_bus_port.sv
// Sixteen-bit strobe host port with wait and refresh arbitration
`timescale 1ns/1ps
`include "slot_port_regs.svh"
// What this block does
// [RULE1] Host presents address then card enables
// [RULE2] Low enable alone: byte on low lanes
// [RULE3] High enable alone: odd byte, upper lanes; here the low lane is always on, so this gives both lanes
// [RULE4] Both enables: sixteen-bit word transfer
// [RULE5] Host space select chooses memory or IO
// [RULE6] IO space uses dedicated read/write strobes
// [RULE7] Cycle stretched while hold is asserted
// [RULE8] Bus configuration latched when reset releases
// [RULE9] Host byte lanes swapped onto chip lanes
// [RULE10] Low address direct, upper bits externally latched
// [RULE11] Chip select from external address decode
// [RULE12] Memory/register select steers access target
// [RULE13] Second write enable is high byte enable
// [RULE14] Host IO write drives write strobe low
// [RULE15] Host IO read drives read strobe low
// [RULE16] Hold output marks data valid or accepted
// [RULE17] Hold host while refresh owns resource
// [RULE18] Bus start and direction tied high
// [RULE19] Internal bus clock derived from clock input
// [RULE20] Board sets endian strap for reset latch
// [RULE21] Strap chooses hold output polarity
// [RULE22] Strap chooses clock ratio two or one
// [RULE23] Registers then memory, aliased every block
// [RULE24] Strobes resynchronised before use
// [RULE25] Hold asserted on select, released on done
module card_slot_host_bus_port #(
  parameter int ADDR_W = `ADDR_W,
  parameter int DATA_W = `DATA_W
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic chip_select_n_i,
  input wire logic mem_reg_select_i,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  input wire logic high_byte_enable_n_i,
  input wire logic bus_start_n_i,
  input wire logic [ADDR_W-1:0] port_addr_in_i,
  input wire logic [DATA_W-1:0] port_data_in_i,
  input wire logic endian_strap_i,
  input wire logic hold_polarity_strap_i,
  input wire logic clock_ratio_strap_i,
  input wire logic refresh_busy_i,
  input wire logic [DATA_W-1:0] core_rdata_i,
  output logic [DATA_W-1:0] port_data_out_o,
  output logic port_data_oe_o,
  output logic slot_hold_o,
  output logic core_req_o,
  output slot_port_pkg::access_s core_access_o,
  output slot_port_pkg::strap_s strap_o,
  output logic bus_clk_en_o
);
  // Two-stage synchronisers for every pin input
  // The bus start pin is tied off by the board and is not used here
  localparam int SYNC_W = 5 + ADDR_W + DATA_W;
  logic [SYNC_W-1:0] sync1_q, sync1_d;
  logic [SYNC_W-1:0] sync2_q, sync2_d;
  logic cs_n_s, mr_s, wr_n_s, rd_n_s, hbe_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] wdata_s;

  always_comb
  begin
    sync1_d = {chip_select_n_i, mem_reg_select_i, write_strobe_n_i,
               read_strobe_n_i, high_byte_enable_n_i, port_addr_in_i,
               port_data_in_i}; // [RULE24]
    sync2_d = sync1_q;
  end

  // Reset to the idle level of every strobe, so no false access follows
  // reset before the pins have been sampled
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sync1_q <= '1;
      sync2_q <= '1;
    end
    else if (clk_en_i)
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign {cs_n_s, mr_s, wr_n_s, rd_n_s, hbe_n_s, addr_s, wdata_s} =
    sync2_q;

  // Straps get their own pair of flip-flops; these run through reset so
  // that a settled value is waiting when reset releases
  slot_port_pkg::strap_s strap_sync1_q, strap_sync1_d;
  slot_port_pkg::strap_s strap_sync2_q, strap_sync2_d;

  always_comb
  begin
    strap_sync1_d.endian = endian_strap_i;
    strap_sync1_d.hold_active_high = hold_polarity_strap_i;
    strap_sync1_d.clock_half = clock_ratio_strap_i; // [RULE24]
    strap_sync2_d = strap_sync1_q;
  end

  always_ff @(posedge mclk_i)
  begin
    if (clk_en_i)
    begin
      strap_sync1_q <= strap_sync1_d;
      strap_sync2_q <= strap_sync2_d;
    end
  end

  // Straps caught in the first enabled cycle after reset release
  // Strobes are ignored until this has happened
  slot_port_pkg::strap_s strap_q, strap_d;
  logic strap_done_q, strap_done_d;

  always_comb
  begin
    strap_d = strap_q;
    strap_done_d = 1'b1;
    if (!strap_done_q)
    begin
      strap_d.endian = strap_sync2_q.endian; // [RULE8]
      strap_d.hold_active_high = strap_sync2_q.hold_active_high; // [RULE21]
      strap_d.clock_half = strap_sync2_q.clock_half; // [RULE22]
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      strap_q <= '0;
      strap_done_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      strap_q <= strap_d;
      strap_done_q <= strap_done_d;
    end
  end

  // Internal bus clock enable: every cycle or every second one
  // At two-to-one the sequencer may only start an access on a tick
  logic div_q, div_d;
  logic bus_tick;
  always_comb
  begin
    div_d = strap_q.clock_half ? ~div_q : 1'b1; // [RULE19] [RULE22]
  end
  assign bus_tick = strap_q.clock_half ? div_q : 1'b1;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      div_q <= 1'b0;
    else if (clk_en_i)
      div_q <= div_d;
  end

  // Byte swap for the endian strap, used in both data directions
  function automatic logic [DATA_W-1:0] swap_bytes(
    input logic [DATA_W-1:0] v
  );
    return {v[`LOW_BYTE], v[`HIGH_BYTE]};
  endfunction

  // Access sequencer
  slot_port_pkg::port_state_e state_q, state_d;
  slot_port_pkg::access_s acc_q, acc_d;
  logic [`CNT_W-1:0] cnt_q, cnt_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic waiting_q, waiting_d;
  logic oe_q, oe_d;
  logic req_q, req_d;
  logic strobe_on;
  logic [1:0] lanes;

  // Low lane always takes part; the high byte enable adds the upper lane
  assign lanes = {~hbe_n_s, 1'b1}; // [RULE2] [RULE3] [RULE4] [RULE13]
  assign strobe_on = !cs_n_s && strap_done_q && (!wr_n_s || !rd_n_s);

  always_comb
  begin
    state_d = state_q;
    acc_d = acc_q;
    cnt_d = cnt_q;
    rdata_d = rdata_q;
    waiting_d = waiting_q;
    oe_d = oe_q;
    req_d = 1'b0;
    case (state_q)
      slot_port_pkg::st_idle:
      begin
        if (strobe_on) // [RULE11]
        begin
          waiting_d = 1'b1; // [RULE25]
          acc_d.write = !wr_n_s; // [RULE14] [RULE15]
          acc_d.to_memory = mr_s; // [RULE12]
          // Upper address bits ignored: block repeats by aliasing
          acc_d.addr = addr_s; // [RULE23]
          acc_d.lanes = lanes;
          acc_d.data = strap_q.endian ? swap_bytes(wdata_s) : wdata_s;
          state_d = slot_port_pkg::st_grant;
        end
      end
      slot_port_pkg::st_grant:
      begin
        // Refresh owns the core: the host stays held until it lets go
        if (!refresh_busy_i && bus_tick) // [RULE17]
        begin
          req_d = 1'b1;
          cnt_d = `ACCESS_CYCLES;
          state_d = slot_port_pkg::st_access;
        end
      end
      slot_port_pkg::st_access:
      begin
        // The host stays held while the count runs down
        if (cnt_q != '0)
          cnt_d = cnt_q - `CNT_W'(1);
        else
        begin
          // Data and the release of hold leave on one edge, so the host
          // never takes stale data
          rdata_d = strap_q.endian ? swap_bytes(core_rdata_i) : core_rdata_i;
          oe_d = !acc_q.write;
          waiting_d = 1'b0; // [RULE16] [RULE7]
          state_d = slot_port_pkg::st_done;
        end
      end
      slot_port_pkg::st_done:
      begin
        // One strobe is one access: wait for the host to let go
        if (cs_n_s || (wr_n_s && rd_n_s))
        begin
          oe_d = 1'b0;
          state_d = slot_port_pkg::st_idle;
        end
      end
      default:
        state_d = slot_port_pkg::st_idle;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_q <= slot_port_pkg::st_idle;
      acc_q <= '0;
      cnt_q <= '0;
      rdata_q <= '0;
      waiting_q <= 1'b0;
      oe_q <= 1'b0;
      req_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state_q <= state_d;
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
      waiting_q <= waiting_d;
      oe_q <= oe_d;
      req_q <= req_d;
    end
  end

  // Registered pin outputs, hold polarity from strap
  // Hold leaves reset high; under an active-high strap that reads as held
  // until the straps are latched on the first cycle after release
  logic hold_q, hold_d;
  logic tick_q;
  always_comb
  begin
    hold_d = waiting_d ~^ strap_d.hold_active_high; // [RULE21] [RULE7]
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      hold_q <= 1'b1;
      tick_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      hold_q <= hold_d;
      tick_q <= div_d;
    end
  end

  assign slot_hold_o = hold_q;
  assign port_data_out_o = rdata_q;
  assign port_data_oe_o = oe_q;
  assign core_req_o = req_q;
  assign core_access_o = acc_q;
  assign strap_o = strap_q;
  assign bus_clk_en_o = tick_q;
endmodule

// ===== pkg/slot_port_regs.svh
// Constants for the card slot host bus port
`ifndef SLOT_PORT_REGS_SVH
`define SLOT_PORT_REGS_SVH
`define ADDR_W 18
`define DATA_W 16
`define SPACE_BIT 17
`define BLOCK_BYTES 32'h0004_0000
`define MEM_BASE 18'h20000
`define ACCESS_CYCLES 4'h2
`define CNT_W 4
`define LOW_BYTE 7:0
`define HIGH_BYTE 15:8
`define STRAP_ENDIAN 0
`define STRAP_HOLD_POL 1
`define STRAP_CLK_RATIO 2
`endif

// ===== pkg/slot_port_pkg.sv
// Types shared by the card slot host bus port
package slot_port_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_grant = 3'b001,
    st_access = 3'b010,
    st_done = 3'b011
  } port_state_e;

  typedef struct packed {
    logic endian;
    logic hold_active_high;
    logic clock_half;
  } strap_s;

  typedef struct packed {
    logic write;
    logic to_memory;
    logic [1:0] lanes;
    logic [17:0] addr;
    logic [15:0] data;
  } access_s;
endpackage

// ===== testbench/slot_port_asserts.sv
// Checker for the card slot host bus port
`timescale 1ns/1ps
module slot_port_asserts (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic endian_strap_i,
  input wire logic hold_polarity_strap_i,
  input wire logic clock_ratio_strap_i,
  input wire logic high_byte_enable_n_i,
  input wire logic refresh_busy_i,
  input wire logic port_data_oe_o,
  input wire logic slot_hold_o,
  input wire logic core_req_o,
  input wire slot_port_pkg::access_s core_access_o,
  input wire slot_port_pkg::strap_s strap_o
);
  logic [2:0] pins;
  assign pins = {endian_strap_i, hold_polarity_strap_i, clock_ratio_strap_i};
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence s_held; slot_hold_o == strap_o.hold_active_high; endsequence
  sequence s_free; slot_hold_o != strap_o.hold_active_high; endsequence
  property p_rst; $fell(reset_i) |-> slot_hold_o && !core_req_o; endproperty
  a_rst: assert property (p_rst)
    else $error("reset values");
  property p_strap; $fell(reset_i) |-> ##[1:2] strap_o == pins; endproperty
  a_strap: assert property (p_strap)
    else $error("straps not latched");
  property p_pulse; core_req_o |=> !core_req_o; endproperty
  a_pulse: assert property (p_pulse)
    else $error("request too long");
  property p_busy; core_req_o |-> !$past(refresh_busy_i); endproperty
  a_busy: assert property (p_busy)
    else $error("request during refresh");
  property p_held; core_req_o |-> s_held; endproperty
  a_held: assert property (p_held)
    else $error("hold not active");
  property p_done; core_req_o |-> ##[1:8] s_free; endproperty
  a_done: assert property (p_done)
    else $error("hold not released");
  property p_lane;
    core_req_o |-> core_access_o.lanes == {!high_byte_enable_n_i, 1'b1};
  endproperty
  a_lane: assert property (p_lane)
    else $error("low lane off");
  property p_oe; $rose(port_data_oe_o) |-> s_free; endproperty
  a_oe: assert property (p_oe)
    else $error("data without release");
endmodule
bind card_slot_host_bus_port slot_port_asserts slot_port_asserts_inst (.*);

// ===== testbench/slot_host_model.sv
// Slot controller model that runs one strobe cycle per call
`timescale 1ns/1ps
module slot_host_model (
  input wire logic mclk_i,
  input wire logic hold_high_i,
  input wire logic slot_hold_i,
  input wire logic [15:0] rdata_i,
  output logic cs_n_o = 1'b1,
  output logic wr_n_o = 1'b1,
  output logic rd_n_o = 1'b1,
  output logic hbe_n_o = 1'b1,
  output logic mr_o = 1'b0,
  output logic [17:0] addr_o = 18'h0,
  output logic [15:0] wdata_o = 16'h0
);
  task automatic xfer(input logic w, input logic [1:0] ln, input logic m,
    input logic [17:0] a, input logic [15:0] d, output logic [15:0] q,
    output logic ok);
    int n;
    @(negedge mclk_i);
    {mr_o, addr_o, hbe_n_o} = {m, a, !ln[1]};
    wdata_o = w ? d : ~wdata_o;
    @(negedge mclk_i);
    {cs_n_o, wr_n_o, rd_n_o} = {1'b0, !w, w};
    n = 0;
    do @(negedge mclk_i); while (slot_hold_i !== hold_high_i && ++n < 60);
    ok = slot_hold_i === hold_high_i;
    do @(negedge mclk_i); while (slot_hold_i === hold_high_i && ++n < 200);
    ok = ok && slot_hold_i === !hold_high_i;
    q = rdata_i;
    @(negedge mclk_i);
    {cs_n_o, wr_n_o, rd_n_o} = 3'h7;
    wdata_o = ~wdata_o;
    repeat (6) @(negedge mclk_i);
  endtask
endmodule

// ===== testbench/card_slot_host_bus_port_bench.sv
// Bench for the card slot host bus port
`timescale 1ns/1ps
module card_slot_host_bus_port_bench;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic busy = 1'b0;
  logic [2:0] sp = 3'h0;
  logic run_en = 1'b1;
  logic tick0;
  logic [15:0] rd = 16'h0;
  logic cs_n, wr_n, rd_n, hbe_n, mr, oe, hold, req, tick;
  logic [17:0] addr;
  logic [15:0] wd, dout;
  slot_port_pkg::access_s acc;
  slot_port_pkg::strap_s st;
  logic [37:0] exp_q[$];
  int mismatches = 0;
  int total_checks = 0;
  always #2.5 mclk_i = ~mclk_i;
  card_slot_host_bus_port card_slot_host_bus_port_inst (.mclk_i(mclk_i),
    .reset_i(reset_i), .clk_en_i(run_en), .chip_select_n_i(cs_n),
    .mem_reg_select_i(mr), .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n),
    .high_byte_enable_n_i(hbe_n), .bus_start_n_i(1'b1),
    .port_addr_in_i(addr), .port_data_in_i(wd), .endian_strap_i(sp[2]),
    .hold_polarity_strap_i(sp[1]), .clock_ratio_strap_i(sp[0]),
    .refresh_busy_i(busy), .core_rdata_i(rd), .port_data_out_o(dout),
    .port_data_oe_o(oe), .slot_hold_o(hold), .core_req_o(req),
    .core_access_o(acc), .strap_o(st), .bus_clk_en_o(tick));
  slot_host_model slot_host_model_inst (.mclk_i(mclk_i),
    .hold_high_i(sp[1]), .slot_hold_i(hold), .rdata_i(dout), .cs_n_o(cs_n),
    .wr_n_o(wr_n), .rd_n_o(rd_n), .hbe_n_o(hbe_n), .mr_o(mr),
    .addr_o(addr), .wdata_o(wd));
  task automatic check(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [15:0] sw(input logic [15:0] v);
    return sp[2] ? {v[7:0], v[15:8]} : v;
  endfunction
  always @(negedge mclk_i)
  begin
    busy <= ($urandom % 4) == 0;
    if (req === 1'b1)
      check(exp_q.size() != 0 && {acc[37:16], acc.write ? acc.data : 16'h0}
        === exp_q.pop_front(), "access");
  end
  task automatic run(input int k);
    logic [1:0] ln;
    logic [17:0] a;
    logic [15:0] d, q, e;
    logic ok;
    ln = {k[1], 1'b1};
    a = 18'($urandom);
    d = 16'($urandom);
    rd = 16'($urandom);
    exp_q.push_back({k[0], k[2], ln, a, k[0] ? sw(d) : 16'h0});
    slot_host_model_inst.xfer(k[0], ln, k[2], a, d, q, ok);
    check(ok, "hold handshake");
    e = sw(rd);
    if (!k[0])
      check(((q ^ e) & {{8{ln[1]}}, 8'hff}) === 16'h0, "read");
  endtask
  initial
  begin
    void'($urandom(51));
    for (int p = 0; p < 2; p++)
    begin
      reset_i = 1'b1;
      sp = {3{p[0]}};
      repeat (10) @(negedge mclk_i);
      reset_i = 1'b0;
      repeat (3) @(negedge mclk_i);
      check(st === sp, "straps");
      check(hold === !sp[1], "idle hold");
      tick0 = tick;
      @(negedge mclk_i);
      check(sp[0] ? (tick !== tick0) : (tick0 & tick), "bus tick");
      run_en = 1'b0;
      tick0 = tick;
      repeat (4) @(negedge mclk_i);
      check(tick === tick0 && hold === !sp[1], "frozen");
      run_en = 1'b1;
      for (int k = 0; k < 8; k++)
        run(k);
      check(oe === 1'b0, "drive left on");
      check(exp_q.size() == 0, "access lost");
    end
    complete_run();
  end
  initial
  begin
    #50000;
    mismatches++;
    complete_run();
  end
endmodule
